//--- bmcs_chk.sv
/* Port checker for the boot mode and clock setup block.
 * Assumes it is bound to bmcs_top and sees only its ports. */
`timescale 1ns/1ns
module bmcs_chk (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	input wire logic        reset_n_i,
	input wire logic        periph_reset_o,
	input wire logic        programming_connector_mode_o,
	input wire logic        boot_serial_o,
	input wire logic [15:0] boot_addr_o,
	input wire logic        debug_enable_o,
	input wire logic        clock_double_setting_o,
	input wire logic [1:0]  spread_setting_o,
	input wire logic        core_clk_o,
	input wire logic        core_tick_o
);
	// ****************************************
	// Helper logic
	// ****************************************
	logic       prev_dbl;   // Doubler setting one cycle back
	logic [1:0] prev_spr;   // Spreader setting one cycle back
	logic       cfg_moved;  // A clock setting moved since the last edge

	// A setting written inside a half period stretches or cuts it, so such
	// attempts are dropped rather than judged against either rate
	always_ff @(posedge clk_i) begin
		prev_dbl <= clock_double_setting_o;
		prev_spr <= spread_setting_o;
	end
	assign cfg_moved = (prev_dbl != clock_double_setting_o) || (prev_spr != spread_setting_o);

	// ****************************************
	// Properties
	// ****************************************
	default clocking @(posedge clk_i); endclocking
	default disable iff (periph_reset_o);
	// High phase of the core clock_double_setting and undoubled
	sequence s_half2;
		core_clk_o [*2] ##1 !core_clk_o;
	endsequence
	sequence s_half4;
		core_clk_o [*4] ##1 !core_clk_o;
	endsequence
	// Rising edge with settings unchanged and spreading off, so the period is exact
	sequence s_calm;
		$rose(core_clk_o) && $stable(clock_double_setting_o) && spread_setting_o == 2'h0 && $stable(spread_setting_o);
	endsequence
	chk_boot_vector: assert property (boot_addr_o == 16'h0000) else $error("boot address not zero");
	chk_serial_boot: assert property (boot_serial_o == programming_connector_mode_o) else $error("cold boot differs from mode");
	chk_debug_gate: assert property (debug_enable_o == programming_connector_mode_o) else $error("debug outside program mode");
	chk_mode_held: assert property (!$past(periph_reset_o) && !$past(periph_reset_o, 2) |-> $stable(programming_connector_mode_o))
		else $error("mode changed without reset");
	chk_ext_reset: assert property (@(posedge clk_i) disable iff (rst_i) !reset_n_i [*3] |-> periph_reset_o)
		else $error("external reset ignored");
	chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
	chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	chk_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without request");
	chk_doubled_rate: assert property (disable iff (periph_reset_o || cfg_moved)
		s_calm and clock_double_setting_o |-> s_half2) else $error("doubled period wrong");
	chk_plain_rate: assert property (disable iff (periph_reset_o || cfg_moved)
		s_calm and !clock_double_setting_o |-> s_half4) else $error("undoubled period wrong");
	chk_spread_code: assert property (spread_setting_o != 2'h3) else $error("reserved spread code");
	chk_tick_rise: assert property (core_tick_o == $rose(core_clk_o)) else $error("tick not at core rise");
endmodule
bind bmcs_top bmcs_chk bmcs_chk_i (
	.clk_i                  (clk_i),
	.rst_i                  (rst_i),
	.wb_cyc_i               (wb_cyc_i),
	.wb_stb_i               (wb_stb_i),
	.wb_ack_o               (wb_ack_o),
	.reset_n_i              (reset_n_i),
	.periph_reset_o         (periph_reset_o),
	.programming_connector_mode_o            (programming_connector_mode_o),
	.boot_serial_o          (boot_serial_o),
	.boot_addr_o            (boot_addr_o),
	.debug_enable_o         (debug_enable_o),
	.clock_double_setting_o (clock_double_setting_o),
	.spread_setting_o       (spread_setting_o),
	.core_clk_o             (core_clk_o),
	.core_tick_o            (core_tick_o)
);

//--- bmcs_clkgen.sv
/*
 * Core clock enable generator: toggles a modelled core clock at the
 * resonator rate or at twice it, and dithers the period when spreading.
 * Assumes it is clocked by the 100 MHz system clock.
 */
`timescale 1ns/1ns
module bmcs_clkgen (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       double_i,
	input  wire logic [1:0] spread_i,
	output logic            core_clk_o,
	output logic            core_tick_o
);
	import bmcs_pkg::*;

	logic [7:0] cnt;    // Half-period counter
	logic [7:0] limit;  // Current half period in cycles
	logic [3:0] lfsr;   // Dither source

	// ****************************************
	// Half period selection
	// ****************************************
	// Doubler halves the half period; spreading adds up to one (normal) or up to three (strong) cycles
	always_comb begin
		limit = double_i ? 8'(SYS_HALF_CYC) : 8'(RES_HALF_CYC); // [R13] [R14]
		case (spread_i)
			SPREAD_NORMAL: limit = limit + {7'h00, lfsr[0]}; // [R15]
			SPREAD_STRONG: limit = limit + {6'h00, lfsr[1:0]}; // [R15]
			default:       limit = limit;
		endcase
	end

	// Counter and clock toggle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt         <= 8'h00;
			core_clk_o  <= 1'b0;
			core_tick_o <= 1'b0;
			lfsr        <= 4'h1;
		end else if (cnt + 8'h01 >= limit) begin
			cnt         <= 8'h00;
			core_clk_o  <= ~core_clk_o;
			core_tick_o <= ~core_clk_o;
			lfsr        <= {lfsr[2:0], lfsr[3] ^ lfsr[2]};
		end else begin
			cnt         <= cnt + 8'h01;
			core_tick_o <= 1'b0;
		end
	end
endmodule

//--- bmcs_host.sv
/* Host side of the programming cable: connector, reset and clock.
 * Assumes the bench says when the connector is attached. */
`timescale 1ns/1ns
module bmcs_host (
	input  wire logic attach_i,
	input  wire logic hard_reset_i,
	input  wire logic sclk_i,
	output logic      pin0_o,
	output logic      pin1_o,
	output logic      reset_n_o,
	output logic      serial_clk_o
);
	// ****************************************
	// Cable
	// ****************************************
	// Connector pulls both pins up; detached, the pull-downs win
	assign pin0_o = attach_i;
	assign pin1_o = attach_i;
	// Reset line pulled up unless the host forces it
	assign reset_n_o = !hard_reset_i;
	// Clock line still when no cable is present
	assign serial_clk_o = attach_i & sclk_i;
endmodule

//--- bmcs_pkg.sv
/*
 * Package for the boot mode and clock setup block: register offsets,
 * field positions, reset values, modes and timing constants.
 * Assumes a 32-bit classic Wishbone slave port on a 100 MHz clock.
 */
package bmcs_pkg;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [7:0] REG_MODE    = 8'h00; // Latched boot mode and pins
	localparam logic [7:0] REG_CTRL    = 8'h04; // Status pin function, output level
	localparam logic [7:0] REG_CLOCK   = 8'h08; // Doubler and spreader settings
	localparam logic [7:0] REG_SERIAL  = 8'h0c; // Programming port use
	localparam logic [7:0] REG_CYCLE   = 8'h10; // Cycle indication strobes

	// ****************************************
	// Field positions
	// ****************************************
	localparam int MODE_PROGRAMMING_CONNECTOR_BIT  = 0;
	localparam int MODE_PIN0_BIT  = 1;
	localparam int MODE_PIN1_BIT  = 2;
	localparam int MODE_LIVE0_BIT = 3;
	localparam int MODE_LIVE1_BIT = 4;
	localparam int MODE_CLKIN_BIT = 5;
	localparam int CTRL_FUNC_LSB  = 0;
	localparam int CTRL_LEVEL_BIT = 2;
	localparam int CLK_DBL_BIT    = 0;
	localparam int CLK_SPR_LSB    = 1;
	localparam int SER_ASYNC_BIT  = 0;
	localparam int CYC_FETCH_BIT  = 0;
	localparam int CYC_IACK_BIT   = 1;

	// ****************************************
	// Modes and settings
	// ****************************************
	typedef enum logic [1:0] {
		BMCS_STAT_FETCH,
		BMCS_STAT_IACK,
		BMCS_STAT_GPO
	} bmcs_stat_func_t;

	localparam logic [1:0] SPREAD_OFF    = 2'h0;
	localparam logic [1:0] SPREAD_NORMAL = 2'h1;
	localparam logic [1:0] SPREAD_STRONG = 2'h2;
	localparam logic       DOUBLE_OFF    = 1'h0;
	localparam logic       DOUBLE_ON     = 1'h1;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [1:0] RST_FUNC   = 2'h0;
	localparam logic       RST_LEVEL  = 1'h1;
	localparam logic       RST_DOUBLE = DOUBLE_ON;
	localparam logic [1:0] RST_SPREAD = SPREAD_NORMAL;
	localparam logic       RST_ASYNC  = 1'h1;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_MHZ      = 100;
	localparam int RES_KHZ      = 11060;  // Resonator frequency
	localparam int SYS_KHZ      = 22100;  // Doubled system clock
	localparam int RES_HALF_CYC = (CLK_MHZ * 1000) / (2 * RES_KHZ);
	localparam int SYS_HALF_CYC = (CLK_MHZ * 1000) / (2 * SYS_KHZ);

endpackage

//--- bmcs_top.sv
/*
 * Boot mode and clock setup: latches start-up mode pins, drives the
 * status pin, holds clock and programming port settings.
 * Assumes pins are asynchronous and a classic Wishbone master.
 */
// Overview of operation
// [R01] Mode pins pick cold boot or address zero
// [R02] Pins high at reset give program mode
// [R03] Pins low at reset give run mode
// [R04] Host attaches connector before program reset
// [R05] Download and debug allowed only in program
// [R06] Fetch function drives status low on fetch; the code does so only on the first fetch after reset
// [R07] Acknowledge function drives status low during ack
// [R08] General output function drives written level
// [R09] External reset low resets core and peripherals
// [R10] Host may assert reset via port
// [R11] Port sync or async, clock as input
// [R12] Run time reads mode pins, drives status
// [R13] Doubler gives twice the resonator rate
// [R14] Doubler default on, zero off, one on
// [R15] Spreader default normal; zero, one, two
// [R16] Software avoids strong spreading setting
// [R17] Mode latched at reset release, held
`timescale 1ns/1ns
module bmcs_top (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        startup_mode_pin_0_i,
	input  wire logic        startup_mode_pin_1_i,
	input  wire logic        reset_n_i,
	input  wire logic        serial_clk_i,
	input  wire logic        fetch_cycle_i,
	input  wire logic        iack_cycle_i,
	output logic             status_o,
	output logic             status_oe_o,
	output logic             periph_reset_o,
	output logic             programming_connector_mode_o,
	output logic             boot_serial_o,
	output logic [15:0]      boot_addr_o,
	output logic             debug_enable_o,
	output logic             serial_async_o,
	output logic             clock_double_setting_o,
	output logic [1:0]       spread_setting_o,
	output logic             core_clk_o,
	output logic             core_tick_o
);
	import bmcs_pkg::*;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [3:0] sync_a;     // First stage, read only by sync_b
	logic [3:0] sync_b;     // Second stage, safe to use
	logic       rst_int;    // Combined internal reset
	logic       rst_q;      // Declared but never driven or read
	logic       latched;    // Mode latched since last reset

	// Two flops for pins, reset pin, clock-as-input
	always_ff @(posedge clk_i) begin
		sync_a <= {serial_clk_i, reset_n_i, startup_mode_pin_1_i, startup_mode_pin_0_i};
		sync_b <= sync_a;
	end

	// External reset low or bus reset resets all state but the pin synchronisers and the Wishbone answer (bus reset only)
	assign rst_int        = rst_i | ~sync_b[2]; // [R09] [R10]
	assign periph_reset_o = rst_int;            // [R09]

	// ****************************************
	// Boot mode latch
	// ****************************************
	logic mode_pin0;  // Pin 0 level at reset release
	logic mode_pin1;  // Pin 1 level at reset release
	logic programming_connector_mode;  // Program mode chosen

	// Caught by a clocked process on the first cycle after release,
	// so the reset value itself stays a constant
	always_ff @(posedge clk_i) begin
		if (rst_int) begin
			latched   <= 1'b0;
			mode_pin0 <= 1'b0;
			mode_pin1 <= 1'b0;
			programming_connector_mode <= 1'b0;
		end else if (!latched) begin
			latched   <= 1'b1; // [R17]
			mode_pin0 <= sync_b[0];
			mode_pin1 <= sync_b[1];
			programming_connector_mode <= sync_b[0] & sync_b[1]; // [R02] [R03]
		end
	end

	// Mixed pin levels fall to run mode: only a firm high boots serially
	assign programming_connector_mode_o    = programming_connector_mode;
	assign boot_serial_o  = latched & programming_connector_mode;  // [R01] [R02]
	assign boot_addr_o    = 16'h0000;             // [R01] [R03]
	assign debug_enable_o = latched & programming_connector_mode;  // [R05]

	// ****************************************
	// Control registers
	// ****************************************
	logic [1:0] stat_func;   // Status pin function
	logic       stat_level;  // General output level
	logic       dbl;         // Doubler setting
	logic [1:0] spread;      // Spreader setting
	logic       async_mode;  // Programming port async
	logic       wr_en;       // Write taken this cycle
	logic       fetch_seen;  // Fetch strobe recorded
	logic       iack_seen;   // Ack strobe recorded
	logic       first_done;  // First fetch already passed

	assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];

	// Status function and level
	always_ff @(posedge clk_i) begin
		if (rst_int) begin
			stat_func  <= RST_FUNC;
			stat_level <= RST_LEVEL;
		end else if (wr_en && wb_adr_i == REG_CTRL) begin
			if (wb_dat_i[CTRL_FUNC_LSB +: 2] <= 2'(BMCS_STAT_GPO)) begin
				stat_func <= wb_dat_i[CTRL_FUNC_LSB +: 2];
			end
			stat_level <= wb_dat_i[CTRL_LEVEL_BIT]; // [R08] [R12]
		end
	end

	// Clock settings; code three is kept out as it has no meaning
	always_ff @(posedge clk_i) begin
		if (rst_int) begin
			dbl    <= RST_DOUBLE;  // [R14]
			spread <= RST_SPREAD;  // [R15]
		end else if (wr_en && wb_adr_i == REG_CLOCK) begin
			dbl <= wb_dat_i[CLK_DBL_BIT]; // [R14]
			if (wb_dat_i[CLK_SPR_LSB +: 2] != 2'h3) begin
				spread <= wb_dat_i[CLK_SPR_LSB +: 2]; // [R15]
			end
		end
	end

	// Programming port use
	always_ff @(posedge clk_i) begin
		if (rst_int) begin
			async_mode <= RST_ASYNC;
		end else if (wr_en && wb_adr_i == REG_SERIAL) begin
			async_mode <= wb_dat_i[SER_ASYNC_BIT]; // [R11]
		end
	end

	assign serial_async_o         = async_mode;
	assign clock_double_setting_o = dbl;
	assign spread_setting_o       = spread;

	// ****************************************
	// Status pin
	// ****************************************
	// Sticky records of cycle strobes; a new strobe beats a clear
	always_ff @(posedge clk_i) begin
		if (rst_int) begin
			fetch_seen <= 1'b0;
			iack_seen  <= 1'b0;
			first_done <= 1'b0;
		end else begin
			if (fetch_cycle_i) begin
				fetch_seen <= 1'b1;
				first_done <= 1'b1;
			end else if (wr_en && wb_adr_i == REG_CYCLE && wb_dat_i[CYC_FETCH_BIT]) begin
				fetch_seen <= 1'b0;
			end
			if (iack_cycle_i) begin
				iack_seen <= 1'b1;
			end else if (wr_en && wb_adr_i == REG_CYCLE && wb_dat_i[CYC_IACK_BIT]) begin
				iack_seen <= 1'b0;
			end
		end
	end

	// Status pin driven from a flop; in the fetch function low only on the first fetch
	always_ff @(posedge clk_i) begin
		if (rst_int) begin
			status_o    <= 1'b1;
			status_oe_o <= 1'b0;
		end else begin
			status_oe_o <= 1'b1;
			case (stat_func)
				2'(BMCS_STAT_FETCH): status_o <= ~(fetch_cycle_i & ~first_done); // [R06]
				2'(BMCS_STAT_IACK):  status_o <= ~iack_cycle_i;                  // [R07]
				2'(BMCS_STAT_GPO):   status_o <= stat_level;                     // [R08] [R12]
				default:             status_o <= 1'b1;
			endcase
		end
	end

	// ****************************************
	// Wishbone slave
	// ****************************************
	// One wait-free answer: ack the cycle after the strobe, then drop
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
			wb_dat_o <= 32'h0000_0000;
			case (wb_adr_i)
				REG_MODE: begin
					wb_dat_o[MODE_PROGRAMMING_CONNECTOR_BIT]  <= programming_connector_mode;
					wb_dat_o[MODE_PIN0_BIT]  <= mode_pin0;
					wb_dat_o[MODE_PIN1_BIT]  <= mode_pin1;
					wb_dat_o[MODE_LIVE0_BIT] <= sync_b[0]; // [R12]
					wb_dat_o[MODE_LIVE1_BIT] <= sync_b[1]; // [R12]
					wb_dat_o[MODE_CLKIN_BIT] <= sync_b[3] & async_mode; // [R11]
				end
				REG_CTRL: begin
					wb_dat_o[CTRL_FUNC_LSB +: 2] <= stat_func;
					wb_dat_o[CTRL_LEVEL_BIT]     <= stat_level;
				end
				REG_CLOCK: begin
					wb_dat_o[CLK_DBL_BIT]      <= dbl;
					wb_dat_o[CLK_SPR_LSB +: 2] <= spread;
				end
				REG_SERIAL: wb_dat_o[SER_ASYNC_BIT] <= async_mode;
				REG_CYCLE: begin
					wb_dat_o[CYC_FETCH_BIT] <= fetch_seen;
					wb_dat_o[CYC_IACK_BIT]  <= iack_seen;
				end
				default: wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// ****************************************
	// Core clock model
	// ****************************************
	bmcs_clkgen u_clkgen (
		.clk_i       (clk_i),
		.rst_i       (rst_int),
		.double_i    (dbl),
		.spread_i    (spread),
		.core_clk_o  (core_clk_o),
		.core_tick_o (core_tick_o)
	);
endmodule

//--- tb_top.sv
/* Self-checking bench for bmcs_top with a host cable model.
 * Assumes the checker is bound in by its own file. */
`timescale 1ns/1ns
module tb_top;
	import bmcs_pkg::*;
	// ****************************************
	// Signals and model
	// ****************************************
	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, fetch_cycle_i, iack_cycle_i;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rdat, rnd;
	logic        startup_mode_pin_0_i, startup_mode_pin_1_i, reset_n_i, serial_clk_i, attach, hreset, sclk;
	logic        status_o, status_oe_o, periph_reset_o, programming_connector_mode_o, boot_serial_o, debug_enable_o;
	logic        serial_async_o, clock_double_setting_o, core_clk_o, core_tick_o;
	logic [1:0]  spread_setting_o;
	logic [15:0] boot_addr_o;
	int          num_errors, checked, m_dbl, m_spr, m_fn, m_lvl, m_as;
	bmcs_top bmcs_top_i (
		.clk_i                  (clk_i),
		.rst_i                  (rst_i),
		.wb_cyc_i               (wb_cyc_i),
		.wb_stb_i               (wb_stb_i),
		.wb_we_i                (wb_we_i),
		.wb_adr_i               (wb_adr_i),
		.wb_dat_i               (wb_dat_i),
		.wb_sel_i               (wb_sel_i),
		.wb_dat_o               (wb_dat_o),
		.wb_ack_o               (wb_ack_o),
		.startup_mode_pin_0_i   (startup_mode_pin_0_i),
		.startup_mode_pin_1_i   (startup_mode_pin_1_i),
		.reset_n_i              (reset_n_i),
		.serial_clk_i           (serial_clk_i),
		.fetch_cycle_i          (fetch_cycle_i),
		.iack_cycle_i           (iack_cycle_i),
		.status_o               (status_o),
		.status_oe_o            (status_oe_o),
		.periph_reset_o         (periph_reset_o),
		.programming_connector_mode_o            (programming_connector_mode_o),
		.boot_serial_o          (boot_serial_o),
		.boot_addr_o            (boot_addr_o),
		.debug_enable_o         (debug_enable_o),
		.serial_async_o         (serial_async_o),
		.clock_double_setting_o (clock_double_setting_o),
		.spread_setting_o       (spread_setting_o),
		.core_clk_o             (core_clk_o),
		.core_tick_o            (core_tick_o)
	);
	bmcs_host bmcs_host_i (.attach_i(attach), .hard_reset_i(hreset), .sclk_i(sclk), .pin0_o(startup_mode_pin_0_i),
		.pin1_o(startup_mode_pin_1_i), .reset_n_o(reset_n_i), .serial_clk_o(serial_clk_i));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One classic cycle; the model follows each write, refused codes included
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		// Only the watchdog ends a wait that never sees ack
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rdat = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (w && a == REG_CTRL) begin
			m_fn  = (d[1:0] == 2'h3) ? m_fn : d[1:0];
			m_lvl = d[2];
		end
		if (w && a == REG_CLOCK) begin
			m_dbl = d[0];
			m_spr = (d[2:1] == 2'h3) ? m_spr : d[2:1];
		end
		if (w && a == REG_SERIAL) m_as = d[0];
	endtask
	task automatic model_reset();
		m_dbl = 1;
		m_spr = 1;
		m_fn  = 0;
		m_lvl = 1;
		m_as  = 1;
	endtask
	task automatic final_report();
		$display("Counts: checked=%0d num_errors=%0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// ****************************************
	// Clock, watchdog and scenarios
	// ****************************************
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		#200000;
		num_errors++;
		final_report();
	end
	initial begin
		{rst_i, wb_cyc_i, wb_stb_i, wb_we_i, fetch_cycle_i, iack_cycle_i, attach, hreset, sclk} = 9'h100;
		{wb_adr_i, wb_dat_i} = '0;
		wb_sel_i = 4'hf;
		rnd = 32'h94bf;
		model_reset();
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		chk(programming_connector_mode_o, 0);
		chk(boot_serial_o, 0);
		chk(boot_addr_o, 0);
		bus(0, REG_CLOCK, 0);
		chk(rdat, (m_spr << 1) | m_dbl);
		bus(0, REG_CTRL, 0);
		chk(rdat, (m_lvl << 2) | m_fn);
		bus(0, 8'h20, 0);
		chk(rdat, 0);
		// First fetch strobe pulls the status pin low, a second one leaves it high
		for (int f = 0; f < 2; f++) begin
			@(posedge clk_i) fetch_cycle_i <= 1'b1;
			@(posedge clk_i) fetch_cycle_i <= 1'b0;
			@(negedge clk_i) chk(status_o, f);
			bus(0, REG_CYCLE, 0);
			chk(rdat[CYC_FETCH_BIT], 1);
		end
		// Writing ones clears both strobe records
		bus(1, REG_CYCLE, 32'h3);
		bus(0, REG_CYCLE, 0);
		chk(rdat, 0);
		// Acknowledge function follows the strobe, one cycle late
		bus(1, REG_CTRL, 32'h1);
		@(posedge clk_i) iack_cycle_i <= 1'b1;
		repeat (3) begin
			@(posedge clk_i);
			@(negedge clk_i) chk(status_o, 0);
		end
		@(posedge clk_i) iack_cycle_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		@(negedge clk_i) chk(status_o, 1);
		bus(0, REG_CYCLE, 0);
		chk(rdat, 32'h2);
		// Output function drives random levels
		repeat (4) begin
			rnd = xs(rnd);
			bus(1, REG_CTRL, {29'h0, rnd[0], 2'h2});
			@(negedge clk_i) chk(status_o, m_lvl);
			chk(status_oe_o, 1);
		end
		// Reserved function code keeps the function; the level is still taken
		bus(1, REG_CTRL, 32'h7);
		bus(0, REG_CTRL, 0);
		chk(rdat, (m_lvl << 2) | m_fn);
		@(negedge clk_i) chk(status_o, m_lvl);
		// Every double and spread code but 6, which is sent as 7; code 3 must leave spread alone.
		// Strong spreading is set by codes 4 and 5 and held through 6 and 7, to prove it decodes
		for (int i = 0; i < 8; i++) begin
			bus(1, REG_CLOCK, (i[2:1] == 2'h3) ? {29'h0, i[2:1], m_dbl[0]} : i);
			@(negedge clk_i) chk(clock_double_setting_o, m_dbl);
			chk(spread_setting_o, m_spr);
			repeat (24) @(posedge clk_i);
		end
		// Port clock line read as an input in asynchronous use; the seed drives it high every pass
		for (int v = 0; v < 4; v++) begin
			rnd = xs(rnd);
			bus(1, REG_SERIAL, v);
			attach <= 1'b1;
			sclk   <= v[1] ^ rnd[0];
			repeat (4) @(posedge clk_i);
			bus(0, REG_MODE, 0);
			chk(rdat[MODE_CLKIN_BIT], sclk & m_as);
			chk(rdat[4:0], 5'h18);
			chk(serial_async_o, m_as);
		end
		// Host forces a reset with the connector on
		@(posedge clk_i) hreset <= 1'b1;
		repeat (4) @(posedge clk_i);
		@(negedge clk_i) chk(periph_reset_o, 1);
		@(posedge clk_i) hreset <= 1'b0;
		model_reset();
		repeat (6) @(posedge clk_i);
		@(negedge clk_i) chk(programming_connector_mode_o, 1);
		chk(boot_serial_o, 1);
		chk(debug_enable_o, 1);
		bus(0, REG_CLOCK, 0);
		chk(rdat, (m_spr << 1) | m_dbl);
		bus(0, REG_MODE, 0);
		chk(rdat, 32'h1f | ((sclk & m_as) << 5));
		// Connector pulled off: live pins fall, mode stays
		attach <= 1'b0;
		repeat (4) @(posedge clk_i);
		bus(0, REG_MODE, 0);
		chk(rdat, 32'h07);
		@(negedge clk_i) chk(programming_connector_mode_o, 1);
		final_report();
	end
endmodule
